// ---- pkg/nvm_access_map.svh ----
`ifndef NVM_ACCESS_MAP_SVH
`define NVM_ACCESS_MAP_SVH

// Register indices on the plain register port
`define DATA_LOW_OFS      4'h0
`define DATA_HIGH_OFS     4'h1
`define ADDR_LOW_OFS      4'h2
`define ADDR_HIGH_OFS     4'h3
`define ACCESS_CTRL_OFS   4'h4
`define UNLOCK_PORT_OFS   4'h5
`define STATUS_OFS        4'h6

// Field positions in the access control register
`define SPACE_BIT         7
`define ABORT_BIT         3
`define ALLOW_BIT         2
`define WTRIG_BIT         1
`define RTRIG_BIT         0
// Field position in the status register
`define DONE_BIT          4

// Unlock keys
`define UNLOCK_KEY1       8'h55
`define UNLOCK_KEY2       8'hAA

// Reset values and erase pattern
`define DATA_RESET        8'h00
`define ERASED_BYTE       8'hFF
`define ERASED_WORD       14'h3FFF

// Read latencies in instruction cycles
`define DATA_READ_CYCLES  2'h1
`define FLASH_READ_CYCLES 2'h2

// Timing
`define CLK_PERIOD_NS     40
`define WRITE_TIME_NS     4000000

`endif

// ---- pkg/nvm_access_pkg.sv ----
package nvm_access_pkg;

    typedef enum logic [2:0] {
        UNLOCK_IDLE  = 3'h1,
        UNLOCK_HALF  = 3'h2,
        UNLOCK_ARMED = 3'h4
    } unlock_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } reg_req_t;

    typedef struct packed {
        logic [7:0]  data_low;
        logic [5:0]  data_high;
        logic [7:0]  addr_low;
        logic [7:0]  addr_high;
        logic        space;
        logic        abort;
        logic        allow;
        logic        wtrig;
        logic        rtrig;
        logic        done;
        unlock_t     unlock;
        logic [1:0]  rd_count;
        logic        w_space;
        logic [10:0] w_addr;
        logic [13:0] w_data;
        logic [19:0] timer;
        logic        hold;
        logic [7:0]  rdata;
    } state_t;

endpackage

// ---- core/eeprom_flash_self_access.sv ----
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Data array is 64 bytes, byte access through low data and address registers.
// - Program words are 14 bits over high:low data; unused upper bits read zero.
// - Program address is high:low address registers, 2K words up to 7FFh.
// - Any 14-bit value may be stored; invalid instructions execute as no-operation.
// - Space select zero routes accesses to data array, one to flash.
// - Read trigger is set-only by firmware, cleared by hardware when done.
// - Data array read result stands in low data register next cycle.
// - Flash read loads high:low data after the second following cycle.
// - No write starts while write allow is zero.
// - Hardware clears write trigger when the write finishes.
// - Data write erases byte, programs it in background, then sets done flag.
// - Flash write halts the core, erases, programs, sets done, then resumes.
// - Peripherals keep running during flash write; interrupts held pending.
// - After flash write, pipelined instruction runs before interrupt branch.
// - An internal timer, not firmware, sets each write's duration.
// - Abort flag set when external or watchdog reset cuts a write short.
// - Those resets leave data, address registers and space select unchanged.
// - Unlock port has no storage; it only takes the unlock sequence.
// - Write trigger accepted only if write allow was set earlier.
`include "nvm_access_map.svh"

module eeprom_flash_self_access #(
    parameter int unsigned WRITE_CYCLES =
        (`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    input  wire logic                     warm_reset,
    input  wire nvm_access_pkg::reg_req_t req,
    output wire logic [7:0]               reg_rdata,
    output wire logic                     core_stall,
    output wire logic                     irq_hold,
    output wire logic                     write_busy
);

    localparam logic [19:0] TIMER_LAST = 20'(WRITE_CYCLES - 1);
    localparam logic [19:0] TIMER_HALF = 20'(WRITE_CYCLES / 2);

    nvm_access_pkg::state_t st;
    nvm_access_pkg::state_t next_st;

    logic [7:0]  eeprom_mem [0:63];
    logic [13:0] flash_mem  [0:2047];

    logic        next_data_we;
    logic        next_flash_we;
    logic [13:0] next_mem_val;

    logic [5:0]  data_ptr;
    logic [10:0] flash_ptr;

    assign data_ptr  = st.addr_low[5:0];
    assign flash_ptr = {st.addr_high[2:0], st.addr_low};

    always_comb begin
        next_st       = st;
        next_data_we  = 1'b0;
        next_flash_we = 1'b0;
        next_mem_val  = `ERASED_WORD;
        next_st.rdata = 8'h00;
        next_st.hold  = 1'b0;

        if (req.read) begin
            if (req.addr == `DATA_LOW_OFS) begin
                next_st.rdata = st.data_low;
            end else if (req.addr == `DATA_HIGH_OFS) begin
                next_st.rdata = {2'h0, st.data_high};
            end else if (req.addr == `ADDR_LOW_OFS) begin
                next_st.rdata = st.addr_low;
            end else if (req.addr == `ADDR_HIGH_OFS) begin
                next_st.rdata = st.addr_high;
            end else if (req.addr == `ACCESS_CTRL_OFS) begin
                next_st.rdata = {st.space, 3'h0, st.abort, st.allow, st.wtrig, st.rtrig};
            end else if (req.addr == `STATUS_OFS) begin
                next_st.rdata = {3'h0, st.done, 4'h0};
            end else begin
                next_st.rdata = 8'h00;
            end
        end

        if (req.write) begin
            if (req.addr == `DATA_LOW_OFS) begin
                next_st.data_low = req.wdata;
            end else if (req.addr == `DATA_HIGH_OFS) begin
                next_st.data_high = req.wdata[5:0];
            end else if (req.addr == `ADDR_LOW_OFS) begin
                next_st.addr_low = req.wdata;
            end else if (req.addr == `ADDR_HIGH_OFS) begin
                next_st.addr_high = req.wdata;
            end else if (req.addr == `ACCESS_CTRL_OFS) begin
                if (!st.rtrig && !st.wtrig) begin
                    next_st.space = req.wdata[`SPACE_BIT];
                end
                next_st.abort = req.wdata[`ABORT_BIT];
                next_st.allow = req.wdata[`ALLOW_BIT];
                if (req.wdata[`RTRIG_BIT] && !st.rtrig && !st.wtrig) begin
                    next_st.rtrig    = 1'b1;
                    next_st.rd_count = next_st.space ? `FLASH_READ_CYCLES
                                                     : `DATA_READ_CYCLES;
                end
                if (req.wdata[`WTRIG_BIT] && st.allow && !st.wtrig && !st.rtrig
                    && st.unlock == nvm_access_pkg::UNLOCK_ARMED) begin
                    next_st.wtrig   = 1'b1;
                    next_st.w_space = next_st.space;
                    next_st.w_addr  = next_st.space ? flash_ptr : {5'h00, data_ptr};
                    next_st.w_data  = next_st.space ? {st.data_high, st.data_low}
                                                    : {6'h00, st.data_low};
                    next_st.timer   = TIMER_LAST;
                end
            end else if (req.addr == `STATUS_OFS) begin
                next_st.done = req.wdata[`DONE_BIT];
            end

            if (req.addr != `UNLOCK_PORT_OFS) begin
                next_st.unlock = nvm_access_pkg::UNLOCK_IDLE;
            end else if (req.wdata == `UNLOCK_KEY1) begin
                next_st.unlock = nvm_access_pkg::UNLOCK_HALF;
            end else if (req.wdata == `UNLOCK_KEY2
                         && st.unlock == nvm_access_pkg::UNLOCK_HALF) begin
                next_st.unlock = nvm_access_pkg::UNLOCK_ARMED;
            end else begin
                next_st.unlock = nvm_access_pkg::UNLOCK_IDLE;
            end
        end

        if (st.rtrig) begin
            if (st.rd_count == 2'h1) begin
                next_st.rtrig = 1'b0;
                if (st.space) begin
                    next_st.data_low  = flash_mem[flash_ptr][7:0];
                    next_st.data_high = flash_mem[flash_ptr][13:8];
                end else begin
                    next_st.data_low = eeprom_mem[data_ptr];
                end
            end else begin
                next_st.rd_count = st.rd_count - 2'h1;
            end
        end

        if (st.wtrig) begin
            if (st.timer == TIMER_HALF) begin
                next_data_we  = !st.w_space;
                next_flash_we = st.w_space;
                next_mem_val  = `ERASED_WORD;
            end
            if (st.timer == 20'h0_0000) begin
                next_data_we  = !st.w_space;
                next_flash_we = st.w_space;
                next_mem_val  = st.w_data;
                next_st.wtrig = 1'b0;
                next_st.done  = 1'b1;
                next_st.hold  = st.w_space;
            end else begin
                next_st.timer = st.timer - 20'h0_0001;
            end
        end

        if (warm_reset) begin
            if (st.wtrig) begin
                next_st.abort = 1'b1;
            end
            next_st.data_low  = st.data_low;
            next_st.data_high = st.data_high;
            next_st.addr_low  = st.addr_low;
            next_st.addr_high = st.addr_high;
            next_st.space     = st.space;
            next_st.wtrig  = 1'b0;
            next_st.rtrig  = 1'b0;
            next_st.allow  = 1'b0;
            next_st.hold   = 1'b0;
            next_st.unlock = nvm_access_pkg::UNLOCK_IDLE;
            next_data_we   = 1'b0;
            next_flash_we  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st <= '{data_low: `DATA_RESET, data_high: 6'h00, addr_low: 8'h00,
                    addr_high: 8'h00, space: 1'b0, abort: 1'b0, allow: 1'b0,
                    wtrig: 1'b0, rtrig: 1'b0, done: 1'b0,
                    unlock: nvm_access_pkg::UNLOCK_IDLE, rd_count: 2'h0,
                    w_space: 1'b0, w_addr: 11'h000, w_data: 14'h0000,
                    timer: 20'h0_0000, hold: 1'b0, rdata: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (next_data_we) begin
            eeprom_mem[st.w_addr[5:0]] <= next_mem_val[7:0];
        end
        if (next_flash_we) begin
            flash_mem[st.w_addr] <= next_mem_val;
        end
    end

    assign reg_rdata  = st.rdata;
    assign write_busy = st.wtrig;
    assign core_stall = st.wtrig & st.w_space;
    assign irq_hold   = core_stall | st.hold;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_ctrl_write(int bitpos);
        req.write && req.addr == `ACCESS_CTRL_OFS && req.wdata[bitpos];
    endsequence

    property p_data_read_next;
        s_ctrl_write(`RTRIG_BIT) ##0 (!st.rtrig && !st.wtrig && !warm_reset
            && !req.wdata[`SPACE_BIT]) |=> st.rtrig ##1 !st.rtrig;
    endproperty
    a_data_read_next: assert property (p_data_read_next)
        else $error("data read did not finish next cycle");

    property p_flash_read_two;
        s_ctrl_write(`RTRIG_BIT) ##0 (!st.rtrig && !st.wtrig && !warm_reset
            && req.wdata[`SPACE_BIT]) ##1 !warm_reset |-> st.rtrig ##1 st.rtrig ##1 !st.rtrig;
    endproperty
    a_flash_read_two: assert property (p_flash_read_two)
        else $error("flash read latency not two cycles");

    property p_high_zero;
        req.read && req.addr == `DATA_HIGH_OFS |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_high_zero: assert property (p_high_zero)
        else $error("unused data bits read nonzero");

    property p_allow_before;
        $rose(st.wtrig) |-> $past(st.allow, 2) && $past(st.unlock) == nvm_access_pkg::UNLOCK_ARMED;
    endproperty
    a_allow_before: assert property (p_allow_before)
        else $error("write started without prior allow");

    property p_done_on_end;
        $fell(st.wtrig) && !$past(warm_reset) |-> st.done && st.timer == 20'h0_0000;
    endproperty
    a_done_on_end: assert property (p_done_on_end)
        else $error("write end without done flag");

    property p_stall_flash;
        st.wtrig && st.w_space |-> core_stall && irq_hold;
    endproperty
    a_stall_flash: assert property (p_stall_flash)
        else $error("flash write did not stall core");

    property p_irq_tail;
        $fell(core_stall) && !$past(warm_reset) |-> irq_hold ##1 !irq_hold;
    endproperty
    a_irq_tail: assert property (p_irq_tail)
        else $error("interrupt hold tail wrong");

    property p_abort;
        warm_reset && st.wtrig |=> st.abort && !st.wtrig;
    endproperty
    a_abort: assert property (p_abort)
        else $error("aborted write not flagged");

    property p_keep_regs;
        warm_reset && !req.write |=> $stable(st.data_low) && $stable(st.addr_low)
            && $stable(st.addr_high) && $stable(st.space) && $stable(st.data_high);
    endproperty
    a_keep_regs: assert property (p_keep_regs)
        else $error("warm reset changed held registers");

    property p_unlock_zero;
        req.read && req.addr == `UNLOCK_PORT_OFS |=> reg_rdata == 8'h00;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port read nonzero");

    property p_timer_span;
        $rose(st.wtrig) |-> st.timer == TIMER_LAST;
    endproperty
    a_timer_span: assert property (p_timer_span)
        else $error("write timer not loaded");

endmodule

// ---- tb/core_model.sv ----
`timescale 1ns/1ps
module core_model (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       core_stall,
    input  wire logic       irq_hold,
    input  wire logic       irq_event,
    output logic            irq_taken,
    output logic [7:0]      held_retired,
    output logic [7:0]      stall_count
);
    logic pending;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pending      <= 1'b0;
            irq_taken    <= 1'b0;
            held_retired <= 8'h00;
            stall_count  <= 8'h00;
        end else begin
            if (irq_event) begin
                pending <= 1'b1;
            end
            if (irq_hold && !core_stall) begin
                held_retired <= held_retired + 8'h01;
            end
            if (pending && !irq_hold) begin
                irq_taken <= 1'b1;
                pending   <= 1'b0;
            end
            if (core_stall) begin
                stall_count <= stall_count + 8'h01;
            end
        end
    end
endmodule

// ---- tb/test_eeprom_flash_self_access.sv ----
`timescale 1ns/1ps
`include "nvm_access_map.svh"
module test_eeprom_flash_self_access;
    localparam int WCYC = 8;
    logic                     ref_clk;
    logic                     reset;
    logic                     warm_reset;
    logic                     irq_event;
    nvm_access_pkg::reg_req_t req;
    logic [7:0]               reg_rdata;
    logic                     core_stall;
    logic                     irq_hold;
    logic                     write_busy;
    logic                     irq_taken;
    logic [7:0]               held_retired;
    logic [7:0]               stall_count;
    logic [7:0]               v;
    int                       n_fail;
    int                       num_checks;
    int                       cycles;
    int                       n;

    eeprom_flash_self_access #(.WRITE_CYCLES(WCYC)) i_eeprom_flash_self_access (
        .ref_clk(ref_clk), .reset(reset), .warm_reset(warm_reset), .req(req),
        .reg_rdata(reg_rdata), .core_stall(core_stall), .irq_hold(irq_hold),
        .write_busy(write_busy));

    core_model i_core_model (
        .ref_clk(ref_clk), .reset(reset), .core_stall(core_stall), .irq_hold(irq_hold),
        .irq_event(irq_event), .irq_taken(irq_taken), .held_retired(held_retired),
        .stall_count(stall_count));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    endtask

    task automatic idle;
        @(posedge ref_clk);
        req <= '0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge ref_clk);
        req <= '0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask

    task automatic start_write(input logic [7:0] ctl);
        wr(`ACCESS_CTRL_OFS, ctl & 8'hFD);
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY1);
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY2);
        wr(`ACCESS_CTRL_OFS, ctl);
        idle();
    endtask

    task automatic wait_done;
        n = 0;
        @(negedge ref_clk);
        while (write_busy === 1'b1 && n < 200) begin
            n++;
            @(negedge ref_clk);
        end
    endtask

    task automatic t_reset;
        rd(`ACCESS_CTRL_OFS);
        chk(v, 8'h00);
        rd(`STATUS_OFS);
        chk(v, 8'h00);
        rd(4'hF);
        chk(v, 8'h00);
        rd(`UNLOCK_PORT_OFS);
        chk(v, 8'h00);
        $display("test reset values done");
    endtask

    task automatic t_refuse;
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY1);
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY2);
        wr(`ACCESS_CTRL_OFS, 8'h02);
        idle();
        @(negedge ref_clk);
        chk({7'h00, write_busy}, 8'h00);
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY1);
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY2);
        wr(`ACCESS_CTRL_OFS, 8'h06);
        idle();
        @(negedge ref_clk);
        chk({7'h00, write_busy}, 8'h00);
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY1);
        wr(`DATA_LOW_OFS, 8'h11);
        wr(`UNLOCK_PORT_OFS, `UNLOCK_KEY2);
        wr(`ACCESS_CTRL_OFS, 8'h06);
        idle();
        rd(`ACCESS_CTRL_OFS);
        chk(v, 8'h04);
        $display("test refused writes done");
    endtask

    task automatic t_data;
        wr(`ADDR_LOW_OFS, 8'h3F);
        wr(`DATA_LOW_OFS, 8'h5A);
        start_write(8'h06);
        wait_done();
        chk(8'(n), 8'(WCYC));
        chk({7'h00, core_stall}, 8'h00);
        rd(`ACCESS_CTRL_OFS);
        chk(v, 8'h04);
        rd(`STATUS_OFS);
        chk(v, 8'h10);
        wr(`STATUS_OFS, 8'h00);
        wr(`DATA_LOW_OFS, 8'h00);
        wr(`ACCESS_CTRL_OFS, 8'h01);
        idle();
        idle();
        rd(`DATA_LOW_OFS);
        chk(v, 8'h5A);
        rd(`ACCESS_CTRL_OFS);
        chk(v, 8'h00);
        $display("test data array done");
    endtask

    task automatic t_flash;
        wr(`ADDR_HIGH_OFS, 8'h07);
        wr(`ADDR_LOW_OFS, 8'hFF);
        wr(`DATA_HIGH_OFS, 8'hFF);
        wr(`DATA_LOW_OFS, 8'hA5);
        rd(`DATA_HIGH_OFS);
        chk(v, 8'h3F);
        start_write(8'h86);
        @(posedge ref_clk);
        irq_event <= 1'b1;
        @(posedge ref_clk);
        irq_event <= 1'b0;
        @(negedge ref_clk);
        chk({7'h00, irq_taken}, 8'h00);
        wait_done();
        idle();
        idle();
        @(negedge ref_clk);
        chk(stall_count, 8'(WCYC));
        chk(held_retired, 8'h01);
        chk({7'h00, irq_taken}, 8'h01);
        wr(`STATUS_OFS, 8'h00);
        wr(`DATA_HIGH_OFS, 8'h00);
        wr(`DATA_LOW_OFS, 8'h00);
        wr(`ACCESS_CTRL_OFS, 8'h81);
        rd(`ACCESS_CTRL_OFS);
        chk(v, 8'h81);
        rd(`DATA_LOW_OFS);
        chk(v, 8'hA5);
        rd(`DATA_HIGH_OFS);
        chk(v, 8'h3F);
        $display("test program flash done");
    endtask

    task automatic t_abort;
        wr(`DATA_LOW_OFS, 8'hC3);
        start_write(8'h86);
        @(posedge ref_clk);
        warm_reset <= 1'b1;
        @(posedge ref_clk);
        warm_reset <= 1'b0;
        @(negedge ref_clk);
        chk({7'h00, write_busy}, 8'h00);
        rd(`ACCESS_CTRL_OFS);
        chk(v, 8'h88);
        rd(`DATA_LOW_OFS);
        chk(v, 8'hC3);
        rd(`ADDR_LOW_OFS);
        chk(v, 8'hFF);
        rd(`ADDR_HIGH_OFS);
        chk(v, 8'h07);
        wr(`ACCESS_CTRL_OFS, 8'h81);
        idle();
        idle();
        rd(`DATA_LOW_OFS);
        chk(v, 8'hA5);
        $display("test write abort done");
    endtask

    initial begin
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        reset = 1'b1;
        warm_reset = 1'b0;
        irq_event = 1'b0;
        req = '0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_refuse();
        t_data();
        t_flash();
        t_abort();
        results();
    end
endmodule
